/* File: design/tll_pkg.sv */
// constants, field layouts and carriers for the three-wire latch loader
// assumes one 100 MHz core clock; all serial pins are asynchronous to it
package tll_pkg;

  localparam int          WORD_W     = 24;
  localparam int          SEL_W      = 2;
  localparam int          PIN_N      = 4;
  localparam logic [23:0] LATCH_RST  = 24'h000000;

  // destination codes carried in the two lowest word bits
  localparam logic [1:0]  SEL_CTRL   = 2'h0;
  localparam logic [1:0]  SEL_REFDIV = 2'h1;
  localparam logic [1:0]  SEL_FBCNT  = 2'h2;
  localparam logic [1:0]  SEL_TEST   = 2'h3;

  // control latch fields
  localparam int          MON_LSB    = 5;
  localparam int          MON_W      = 3;
  localparam int          PD_LSB     = 20;
  localparam int          PD_W       = 2;
  localparam logic [2:0]  MON_LOCK   = 3'h1;
  localparam logic [2:0]  MON_RFDIV  = 3'h2;
  localparam logic [2:0]  MON_REFDIV = 3'h4;

  // apb map, byte addresses
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_REFDIV = 8'h04;
  localparam logic [7:0]  ADDR_FBCNT  = 8'h08;
  localparam logic [7:0]  ADDR_TEST   = 8'h0c;
  localparam logic [7:0]  ADDR_SHIFT  = 8'h10;
  localparam logic [7:0]  ADDR_STATUS = 8'h14;
  localparam logic [7:0]  ADDR_CFG    = 8'h18;
  localparam logic        CFG_RST     = 1'b1;
  localparam logic [7:0]  LOAD_CNT_RST = 8'h00;

  // pin order inside the synchroniser bundle
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch_load_strobe;
    logic chip_enable;
  } tll_pins_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } tll_apb_req_t;

endpackage

/* File: design/tll_sync_edge.sv */
// two-flop synchroniser per pin, plus a third stage for edge finding
// assumes pins are asynchronous to clk and slower than half its rate
`timescale 1ns/1ps
module tll_sync_edge
  import tll_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire tll_pins_t pins_async,
  output tll_pins_t      level,
  output tll_pins_t      rise
);

  tll_pins_t meta;
  tll_pins_t sync;
  tll_pins_t prev;
  tll_pins_t next_meta;
  tll_pins_t next_sync;
  tll_pins_t next_prev;

  always_comb begin
    next_meta = pins_async;
    next_sync = meta;
    next_prev = sync;
  end

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise  = sync & ~prev;

endmodule

/* File: design/tll_latch_loader.sv */
// three-wire serial programming port with four word latches and apb view
// assumes host drives sclk/sdata/strobe/ce slowly (160 ns serial period)
// and that lock_detect, rf_div_clk, ref_div_clk come from clk logic
`timescale 1ns/1ps
module tll_latch_loader
  import tll_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        latch_load_strobe,
  input  wire logic        chip_enable,
  input  wire logic        lock_detect,
  input  wire logic        rf_div_clk,
  input  wire logic        ref_div_clk,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             monitor_output_pin,
  output logic             pump_output_oe,
  output logic             powered_up
);

  tll_pins_t pins_async;
  tll_pins_t pin_level;
  tll_pins_t pin_rise;

  assign pins_async = '{sclk: sclk, sdata: sdata,
                        latch_load_strobe: latch_load_strobe,
                        chip_enable: chip_enable};

  // no decode sees a raw pin: two flops first, then a third
  // stage so each pin rise becomes a single-cycle pulse
  tll_sync_edge u_sync (
    .clk        (clk),
    .rst        (rst),
    .pins_async (pins_async),
    .level      (pin_level),
    .rise       (pin_rise)
  );

  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] latch_ctrl;
  logic [WORD_W-1:0] latch_refdiv;
  logic [WORD_W-1:0] latch_fbcnt;
  logic [WORD_W-1:0] latch_test;
  logic [7:0]        load_count;
  logic              serial_enable;
  logic [WORD_W-1:0] next_shift_word;
  logic [WORD_W-1:0] next_latch_ctrl;
  logic [WORD_W-1:0] next_latch_refdiv;
  logic [WORD_W-1:0] next_latch_fbcnt;
  logic [WORD_W-1:0] next_latch_test;
  logic [7:0]        next_load_count;
  logic [SEL_W-1:0]  latch_select;

  // word bits 1:0 are latch_select_high_bit, latch_select_low_bit
  assign latch_select = shift_word[SEL_W-1:0];

  logic apb_write;
  assign apb_write = psel & penable & pready & pwrite;

  // shift and load share one process: a strobe rise in the cycle of
  // a clock rise still loads the word as it stood before that shift
  always_comb begin
    next_shift_word   = shift_word;
    next_latch_ctrl   = latch_ctrl;
    next_latch_refdiv = latch_refdiv;
    next_latch_fbcnt  = latch_fbcnt;
    next_latch_test   = latch_test;
    next_load_count   = load_count;
    // msb first, newest bit lands lowest
    if (pin_rise.sclk && serial_enable) begin
      next_shift_word = {shift_word[WORD_W-2:0], pin_level.sdata};
    end
    if (pin_rise.latch_load_strobe && serial_enable) begin
      next_load_count = load_count + 8'h01;
      unique case (latch_select)
        SEL_CTRL:   next_latch_ctrl   = shift_word;
        SEL_REFDIV: next_latch_refdiv = shift_word;
        SEL_FBCNT:  next_latch_fbcnt  = shift_word;
        SEL_TEST:   next_latch_test   = shift_word;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_word   <= LATCH_RST;
      latch_ctrl   <= LATCH_RST;
      latch_refdiv <= LATCH_RST;
      latch_fbcnt  <= LATCH_RST;
      latch_test   <= LATCH_RST;
      load_count   <= LOAD_CNT_RST;
    end else begin
      shift_word   <= next_shift_word;
      latch_ctrl   <= next_latch_ctrl;
      latch_refdiv <= next_latch_refdiv;
      latch_fbcnt  <= next_latch_fbcnt;
      latch_test   <= next_latch_test;
      load_count   <= next_load_count;
    end
  end

  // power and monitor outputs
  logic [PD_W-1:0]  pd_bits;
  logic [MON_W-1:0] mon_sel;
  logic             next_powered_up;
  logic             next_pump_oe;
  logic             next_monitor;

  // pump follows the power state, so it never drives while the
  // part is down, whichever of pin or power-down bits caused it
  assign pd_bits = latch_ctrl[PD_LSB +: PD_W];
  assign mon_sel = latch_ctrl[MON_LSB +: MON_W];

  always_comb begin
    // power-down bits still gate power up
    next_powered_up = pin_level.chip_enable & ~(|pd_bits);
    next_pump_oe    = next_powered_up;
    // one clk of latency on the monitor; divided signals must stay
    // well below half the core rate to pass through intact
    // monitor source select
    unique case (mon_sel)
      MON_LOCK:   next_monitor = lock_detect;
      MON_RFDIV:  next_monitor = rf_div_clk;
      MON_REFDIV: next_monitor = ref_div_clk;
      default:    next_monitor = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powered_up         <= 1'b0;
      pump_output_oe     <= 1'b0;
      monitor_output_pin <= 1'b0;
    end else begin
      powered_up         <= next_powered_up;
      pump_output_oe     <= next_pump_oe;
      monitor_output_pin <= next_monitor;
    end
  end

  // apb slave: one wait state so every answer comes from a flop
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;
  logic        next_serial_enable;

  // latch words are 24 bits; the upper byte always reads zero
  function automatic logic [31:0] tll_pad(input logic [WORD_W-1:0] w);
    tll_pad = {8'h00, w};
  endfunction

  always_comb begin
    next_pready        = psel & penable & ~pready;
    next_pslverr       = 1'b0;
    next_prdata        = 32'h00000000;
    next_serial_enable = serial_enable;
    if (psel && penable && !pready) begin
      unique case (paddr)
        ADDR_CTRL:   next_prdata = tll_pad(latch_ctrl);
        ADDR_REFDIV: next_prdata = tll_pad(latch_refdiv);
        ADDR_FBCNT:  next_prdata = tll_pad(latch_fbcnt);
        ADDR_TEST:   next_prdata = tll_pad(latch_test);
        ADDR_SHIFT:  next_prdata = tll_pad(shift_word);
        ADDR_STATUS: next_prdata = {20'h00000, load_count,
                                    powered_up, pin_level.chip_enable,
                                    pd_bits};
        ADDR_CFG:    next_prdata = {31'h00000000, serial_enable};
        default:     next_pslverr = 1'b1;
      endcase
      if (pwrite && paddr != ADDR_CFG) begin
        next_pslverr = 1'b1;
      end
    end
    // write lands at the edge that samples pready high, the same
    // edge at which the master takes its answer
    if (apb_write && paddr == ADDR_CFG) begin
      next_serial_enable = pwdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      prdata        <= 32'h00000000;
      serial_enable <= CFG_RST;
    end else begin
      pready        <= next_pready;
      pslverr       <= next_pslverr;
      prdata        <= next_prdata;
      serial_enable <= next_serial_enable;
    end
  end

endmodule

/* File: bench/tll_latch_loader_assertions.sv */
// port-side checker for the three-wire latch loader
// assumes standard apb spacing from the master
`timescale 1ns/1ps
module tll_latch_loader_assertions
  import tll_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_enable,
  input wire logic       lock_detect,
  input wire logic       rf_div_clk,
  input wire logic       ref_div_clk,
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       monitor_output_pin,
  input wire logic       pump_output_oe,
  input wire logic       powered_up
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  property p_oe_pwr;
    pump_output_oe == powered_up &&
      (!pump_output_oe || $past(chip_enable, 3));
  endproperty
  a_oe_pwr: assert property (p_oe_pwr) else $error("pump enable off");
  property p_ce_low;
    !chip_enable [*4] |=> !powered_up;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("up while disabled");
  property p_pwr_rise;
    $rose(powered_up) |-> chip_enable;
  endproperty
  a_pwr_rise: assert property (p_pwr_rise) else $error("bad power up");
  property p_mon_src;
    monitor_output_pin |-> $past(lock_detect || rf_div_clk || ref_div_clk);
  endproperty
  a_mon_src: assert property (p_mon_src) else $error("monitor no source");
  property p_ready_next;
    s_take |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_ready_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
  property p_err_write;
    s_take ##0 (pwrite && paddr != ADDR_CFG) |=> pslverr;
  endproperty
  a_err_write: assert property (p_err_write) else $error("write accepted");
endmodule

bind tll_latch_loader tll_latch_loader_assertions CHK (.clk, .rst,
  .chip_enable, .lock_detect, .rf_div_clk, .ref_div_clk, .paddr, .psel,
  .penable, .pwrite, .pready, .pslverr, .monitor_output_pin,
  .pump_output_oe, .powered_up);

/* File: bench/tll_host.sv */
// host model driving the three serial programming pins
// assumes a 100 MHz clk; serial period is 16 clk, 160 ns
`timescale 1ns/1ps
module tll_host (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdata,
  output logic      latch_load_strobe
);
  initial begin
    sclk = 0;
    sdata = 0;
    latch_load_strobe = 0;
  end
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata <= w[i];
      repeat (8) @(posedge clk);
      sclk <= 1;
      repeat (8) @(posedge clk);
      sclk <= 0;
    end
    // idle line shows the inverse of the last bit
    sdata <= ~w[0];
  endtask
  task automatic load();
    repeat (8) @(posedge clk);
    latch_load_strobe <= 1;
    repeat (8) @(posedge clk);
    latch_load_strobe <= 0;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* File: bench/tll_latch_loader_bench.sv */
// self-checking bench for the three-wire latch loader
// assumes host model drives serial pins, bench drives apb
`timescale 1ns/1ps
module tll_latch_loader_bench;
  import tll_pkg::*;
  logic        clk, rst, ce, ld, rfd, rfr, psel, penable, pwrite;
  logic        pready, pslverr, mon, oe, pwr, sclk, sdata, stb, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, checks_done;
  tll_host HOST (.clk, .sclk, .sdata, .latch_load_strobe(stb));
  tll_latch_loader DUT (.clk, .rst, .sclk, .sdata, .latch_load_strobe(stb),
    .chip_enable(ce), .lock_detect(ld), .rf_div_clk(rfd),
    .ref_div_clk(rfr), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .monitor_output_pin(mon), .pump_output_oe(oe),
    .powered_up(pwr));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    cmp(rd, exp);
    cmp(err, 0);
  endtask
  task automatic t_reset();
    rchk(ADDR_CFG, 1);
    rchk(ADDR_CTRL, 0);
    rchk(ADDR_STATUS, 32'hc);
    apb(1, ADDR_CTRL, 32'h5);
    cmp(err, 1);
    apb(0, 8'h1c, 0);
    cmp(err, 1);
  endtask
  task automatic t_order();
    logic [23:0] w [3] = '{24'h123451, 24'h000020, 24'habcde2};
    logic [7:0]  a [3] = '{ADDR_REFDIV, ADDR_CTRL, ADDR_FBCNT};
    for (int k = 0; k < 3; k++) begin
      HOST.send(w[k]);
      HOST.load();
    end
    for (int k = 0; k < 3; k++) rchk(a[k], {8'h0, w[k]});
    rchk(ADDR_TEST, 0);
    rchk(ADDR_STATUS, 32'h3c);
  endtask
  task automatic t_noload();
    HOST.send(24'h5a5a50);
    rchk(ADDR_SHIFT, 32'h5a5a50);
    rchk(ADDR_CTRL, 32'h20);
    apb(1, ADDR_CFG, 0);
    cmp(err, 0);
    rchk(ADDR_CFG, 0);
    HOST.send(24'h000040);
    HOST.load();
    rchk(ADDR_CTRL, 32'h20);
    rchk(ADDR_SHIFT, 32'h5a5a50);
    rchk(ADDR_STATUS, 32'h3c);
    apb(1, ADDR_CFG, 1);
    cmp(err, 0);
  endtask
  task automatic t_power();
    ce <= 0;
    repeat (6) @(posedge clk);
    cmp(pwr, 0);
    cmp(oe, 0);
    ce <= 1;
    repeat (6) @(posedge clk);
    cmp(pwr, 1);
    cmp(oe, 1);
    HOST.send(24'h100020);
    HOST.load();
    cmp(pwr, 0);
    cmp(oe, 0);
  endtask
  task automatic t_mon();
    logic [2:0] c [3] = '{MON_LOCK, MON_RFDIV, MON_REFDIV};
    logic [2:0] p;
    for (int k = 0; k < 3; k++) begin
      HOST.send({16'h0, c[k], 5'h0});
      HOST.load();
      for (int q = 0; q < 2; q++) begin
        p = q ? 3'b010 : 3'b101;
        {ld, rfd, rfr} <= p;
        repeat (3) @(posedge clk);
        cmp(mon, p[2-k]);
      end
    end
    HOST.send(24'h000000);
    HOST.load();
    {ld, rfd, rfr} <= 3'b111;
    repeat (3) @(posedge clk);
    cmp(mon, 0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rst = 1;
    ce = 1;
    {ld, rfd, rfr} = 0;
    {psel, penable, pwrite} = 0;
    paddr = 0;
    pwdata = 0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 0;
    t_reset();
    t_order();
    t_noload();
    t_power();
    t_mon();
    close_out();
  end
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
